/* File: logic/sdr_sdram_core.sv */
`timescale 1ns/1ps
module sdr_sdram_core
  import sdram_pkg::*;
#(
  parameter int ROW_W  = 12,
  parameter int COL_W  = 8,
  parameter int BANK_W = 2,
  parameter int DATA_W = 32
)(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // command pins
  input  wire logic                  cke,
  input  wire logic                  cs_n,
  input  wire logic                  ras_n,
  input  wire logic                  cas_n,
  input  wire logic                  we_n,
  input  wire logic [BANK_W-1:0]     ba,
  input  wire logic [ROW_W-1:0]      addr,
  input  wire logic [DATA_W/8-1:0]   dqm,
  // data bus
  input  wire logic [DATA_W-1:0]     dq_in,
  output logic      [DATA_W-1:0]     dq_out,
  output logic      [DATA_W/8-1:0]   dq_oe,
  // option strap
  input  wire logic                  auto_grade,
  // status
  output logic      [(1<<BANK_W)-1:0] bank_open,
  output logic                       burst_active,
  output pwr_state_t                 pwr_state,
  output logic      [ROW_W-1:0]      mode_reg
);

  localparam int NBANK = 1 << BANK_W;
  localparam int LANES = DATA_W / 8;
  localparam int IDX_W = BANK_W + ROW_W + COL_W;

  ////////////////////////////////////////////////////////////////////////
  // storage array
  logic [DATA_W-1:0] mem [0:(1<<IDX_W)-1];

  logic [2:0]        cmd;
  logic              cmd_ok;
  logic              clk_on;
  logic              col_cmd;
  logic [COL_W-1:0]  bl_mask;
  logic              full_page;
  logic              adv;
  logic              last;
  logic              ap_done;
  logic [BANK_W-1:0] ap_bank;
  logic [BANK_W-1:0] burst_bank;
  logic [COL_W-1:0]  burst_start;
  logic [COL_W-1:0]  burst_cnt;
  logic              burst_wr;
  logic              burst_ap;
  logic [COL_W-1:0]  acc_col;
  logic [BANK_W-1:0] acc_bank;
  logic              acc_en;
  logic              acc_wr;
  logic [IDX_W-1:0]  acc_idx;
  logic [ROW_W-1:0]  open_row [0:NBANK-1];
  pwr_state_t        pwr_reg;
  pwr_state_t        pwr_next;

  ////////////////////////////////////////////////////////////////////////
  // command decode
  assign cmd = {ras_n, cas_n, we_n};
  // clock live only with gate high
  assign clk_on = cke && (pwr_reg == PWR_RUN);
  assign cmd_ok = !cs_n && clk_on;
  // column command needs an open row
  assign col_cmd = cmd_ok && (cmd == CMD_RD || cmd == CMD_WR) && bank_open[ba];

  ////////////////////////////////////////////////////////////////////////
  // mode load
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg <= MODE_RESET;
    end else if (cmd_ok && cmd == CMD_LMR && bank_open == '0) begin
      mode_reg <= addr;
    end
  end

  always_comb begin
    full_page = 1'b0;
    case (mode_reg[MODE_BL_LSB+:3])
      BL_1:    bl_mask = COL_W'(8'h00);
      BL_2:    bl_mask = COL_W'(8'h01);
      BL_4:    bl_mask = COL_W'(8'h03);
      BL_8:    bl_mask = COL_W'(8'h07);
      BL_FULL: begin
        bl_mask   = '1;
        full_page = 1'b1;
      end
      default: bl_mask = COL_W'(8'h00);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // power state selection
  always_comb begin
    case (pwr_reg)
      PWR_RUN: begin
        if (cke) begin
          pwr_next = PWR_RUN;
        end else if (burst_active) begin
          pwr_next = PWR_SUSPEND;
        end else if (bank_open != '0) begin
          pwr_next = PWR_PD_ACT;
        end else if (!cs_n && cmd == CMD_REF && !auto_grade) begin
          pwr_next = PWR_SELF;
        end else begin
          pwr_next = PWR_PD_PRE;
        end
      end
      // exit as soon as gate seen high
      PWR_PD_PRE, PWR_PD_ACT, PWR_SUSPEND, PWR_SELF: begin
        pwr_next = cke ? PWR_RUN : pwr_reg;
      end
      default: pwr_next = PWR_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pwr_reg <= PWR_RUN;
    end else begin
      pwr_reg <= pwr_next;
    end
  end

  assign pwr_state = pwr_reg;

  ////////////////////////////////////////////////////////////////////////
  // burst runs regardless of select
  // terminate edge carries no beat, so no stray write or read
  assign adv  = burst_active && clk_on && !col_cmd && !(cmd_ok && cmd == CMD_BST);
  assign last = (burst_cnt == bl_mask) && !full_page;

  // any new column restarts the burst
  always_ff @(posedge clk) begin
    if (rst) begin
      burst_active <= 1'b0;
      burst_cnt    <= '0;
      burst_start  <= '0;
      burst_bank   <= '0;
      burst_wr     <= 1'b0;
      burst_ap     <= 1'b0;
    end else if (col_cmd) begin
      burst_active <= (bl_mask != '0);
      burst_cnt    <= COL_W'(1);
      burst_start  <= addr[COL_W-1:0];
      burst_bank   <= ba;
      burst_wr     <= (cmd == CMD_WR);
      burst_ap     <= addr[AP_BIT];
    end else if (cmd_ok && cmd == CMD_BST) begin
      burst_active <= 1'b0;
    end else if (adv) begin
      burst_active <= !last;
      burst_cnt    <= burst_cnt + COL_W'(1);
    end
  end

  // sequential wraps in block, interleave xors
  always_comb begin
    if (col_cmd) begin
      acc_col  = addr[COL_W-1:0];
      acc_bank = ba;
    end else if (mode_reg[MODE_BT_BIT] && !full_page) begin
      acc_col  = burst_start ^ burst_cnt;
      acc_bank = burst_bank;
    end else begin
      acc_col  = (burst_start & ~bl_mask) | ((burst_start + burst_cnt) & bl_mask);
      acc_bank = burst_bank;
    end
  end

  assign acc_en  = col_cmd || adv;
  assign acc_wr  = col_cmd ? (cmd == CMD_WR) : burst_wr;
  assign acc_idx = {acc_bank, open_row[acc_bank], acc_col};

  // precharge when the last beat goes
  // bit 10 asks for auto precharge
  assign ap_done = (col_cmd && bl_mask == '0 && addr[AP_BIT]) || (adv && last && burst_ap);
  assign ap_bank = col_cmd ? ba : burst_bank;

  ////////////////////////////////////////////////////////////////////////
  // per-bank row state; banks are independent so one may close while another bursts
  genvar gb;
  generate
    for (gb = 0; gb < NBANK; gb++) begin : g_bank
      always_ff @(posedge clk) begin
        if (rst) begin
          bank_open[gb] <= 1'b0;
          open_row[gb]  <= '0;
        end else if (cmd_ok && cmd == CMD_ACT && ba == BANK_W'(gb)) begin
          bank_open[gb] <= 1'b1;
          open_row[gb]  <= addr;
        end else if ((cmd_ok && cmd == CMD_PRE && (addr[AP_BIT] || ba == BANK_W'(gb)))
                     || (ap_done && ap_bank == BANK_W'(gb))) begin
          bank_open[gb] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // masked write bytes keep old value
  always_ff @(posedge clk) begin
    if (acc_en && acc_wr) begin
      for (int l = 0; l < LANES; l++) begin
        if (!dqm[l]) begin
          mem[acc_idx][l*8 +: 8] <= dq_in[l*8 +: 8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read pipeline freezes during suspend so data holds on the bus
  logic [DATA_W-1:0]  rd_data [0:RD_STAGES-1];
  logic [RD_STAGES-1:0] rd_vld;
  logic [LANES-1:0]   dqm_d [0:DQM_LAT-1];
  logic [1:0]         cl_sel;

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_vld <= '0;
    end else if (clk_on) begin
      rd_vld <= {rd_vld[RD_STAGES-2:0], acc_en && !acc_wr};
    end
  end

  always_ff @(posedge clk) begin
    if (clk_on) begin
      rd_data[0] <= mem[acc_idx];
      for (int k = 1; k < RD_STAGES; k++) begin
        rd_data[k] <= rd_data[k-1];
      end
    end
  end

  // mask reaches the drivers two clocks on
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int k = 0; k < DQM_LAT; k++) begin
        dqm_d[k] <= '1;
      end
    end else begin
      dqm_d[0] <= dqm;
      for (int k = 1; k < DQM_LAT; k++) begin
        dqm_d[k] <= dqm_d[k-1];
      end
    end
  end

  // latency codes outside 1..3 fall back to the longest
  always_comb begin
    case (mode_reg[MODE_CL_LSB+:3])
      3'h1:    cl_sel = 2'h0;
      3'h2:    cl_sel = 2'h1;
      default: cl_sel = 2'h2;
    endcase
  end

  assign dq_out = rd_data[cl_sel];
  assign dq_oe  = rd_vld[cl_sel] ? ~dqm_d[DQM_LAT-1] : '0;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_cs_mask;
    cs_n && !burst_active |=> $stable(bank_open) && $stable(mode_reg);
  endproperty
  a_cs_mask: assert property (p_cs_mask) else $error("command taken with select high");

  property p_act_open;
    cmd_ok && cmd == CMD_ACT |=> bank_open[$past(ba)] && open_row[$past(ba)] == $past(addr);
  endproperty
  a_act_open: assert property (p_act_open) else $error("active did not open row");

  property p_col_start;
    col_cmd && bl_mask != '0 |=> burst_start == $past(addr[COL_W-1:0]) && burst_cnt == COL_W'(1);
  endproperty
  a_col_start: assert property (p_col_start) else $error("start column not taken");

  property p_cnt_step;
    adv && !last |=> burst_cnt == $past(burst_cnt) + COL_W'(1) && burst_active;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("burst counter stalled");

  property p_suspend;
    burst_active && !cke && !col_cmd |=> $stable(burst_cnt) && pwr_reg == PWR_SUSPEND;
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend did not freeze");

  property p_pre_all;
    cmd_ok && cmd == CMD_PRE && addr[AP_BIT] |=> bank_open == '0;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all left a row open");

  property p_auto_pre;
    adv && last && burst_ap |=> !bank_open[$past(burst_bank)] && !burst_active;
  endproperty
  a_auto_pre: assert property (p_auto_pre) else $error("auto precharge missed");

  property p_dqm_hiz;
    dqm[0] |-> ##2 !dq_oe[0];
  endproperty
  a_dqm_hiz: assert property (p_dqm_hiz) else $error("masked lane driven");

  property p_no_self;
    auto_grade |-> pwr_reg != PWR_SELF;
  endproperty
  a_no_self: assert property (p_no_self) else $error("self refresh on automotive grade");

  c_wr_burst: cover property (col_cmd && cmd == CMD_WR ##1 adv ##1 adv);
  c_rd_data:  cover property (col_cmd && cmd == CMD_RD ##[1:3] dq_oe != '0);
  c_self:     cover property (pwr_reg == PWR_SELF ##1 pwr_reg == PWR_RUN);
  c_pd_act:   cover property (pwr_reg == PWR_PD_ACT);

endmodule : sdr_sdram_core

/* File: logic/sdram_pkg.sv */
package sdram_pkg;

  // command code {ras_n, cas_n, we_n} with chip select low
  localparam logic [2:0] CMD_LMR = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_RD  = 3'h5;
  localparam logic [2:0] CMD_BST = 3'h6;

  // address fields
  localparam int AP_BIT     = 10;
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BT_BIT = 3;
  localparam int MODE_CL_LSB = 4;

  // burst length codes
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;

  // mode after reset: sequential, burst of one, latency two
  localparam logic [11:0] MODE_RESET = 12'h020;

  // read pipeline depth and mask latency in clocks
  localparam int RD_STAGES = 3;
  localparam int DQM_LAT   = 2;

  typedef enum logic [4:0] {
    PWR_RUN     = 5'h01,
    PWR_PD_PRE  = 5'h02,
    PWR_PD_ACT  = 5'h04,
    PWR_SUSPEND = 5'h08,
    PWR_SELF    = 5'h10
  } pwr_state_t;

endpackage : sdram_pkg

/* File: test/ctrl_model.sv */
`timescale 1ns/1ps
module ctrl_model
  import sdram_pkg::*;
(
  // clock
  input  wire logic        clk,
  // command pins
  output logic             cke,
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic [1:0]       ba,
  output logic [11:0]      addr,
  output logic [3:0]       dqm,
  output logic [31:0]      dq_wr,
  // option strap
  output logic             auto_grade
);
  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    ba = 2'h0;
    addr = 12'h000;
    dqm = 4'h0;
    dq_wr = 32'h0;
    auto_grade = 1'b0;
  end
  //////////////////////////////////////////////////////////////
  // bench opens rows first
  task automatic issue(input logic c, input logic [2:0] code, input logic [1:0] b,
                       input logic [11:0] a, input logic [3:0] m, input logic [31:0] d);
    cs_n = c;
    {ras_n, cas_n, we_n} = code;
    ba = b;
    addr = a;
    dqm = m;
    dq_wr = d;
    @(negedge clk);
  endtask : issue
  // deselected address wanders; command and bank lines hold
  task automatic beat(input logic [31:0] d, input logic [3:0] m);
    cs_n = 1'b1;
    addr = ~addr;
    dq_wr = d;
    dqm = m;
    @(negedge clk);
  endtask : beat
  task automatic idle(input int n);
    repeat (n) begin
      cs_n = 1'b1;
      {ras_n, cas_n, we_n} = ~{ras_n, cas_n, we_n};
      addr = ~addr;
      dq_wr = ~dq_wr;
      @(negedge clk);
    end
  endtask : idle
  // strap only raised for refresh refusal
  task automatic set_gate(input logic g, input logic s);
    cke = g;
    auto_grade = s;
  endtask : set_gate
endmodule : ctrl_model

/* File: test/test_sdr_sdram_core.sv */
`timescale 1ns/1ps
module test_sdr_sdram_core
  import sdram_pkg::*;
;
  logic        clk, rst, cke, cs_n, ras_n, cas_n, we_n, auto_grade, burst_active;
  logic [1:0]  ba;
  logic [11:0] addr, mode_reg;
  logic [3:0]  dqm, dq_oe, bank_open;
  logic [31:0] dq_in, dq_out;
  pwr_state_t  pwr_state;
  int          mismatches = 0;
  int          compares = 0;
  int          cycles = 0;
  localparam logic [31:0] DB = 32'hD0D00000;
  localparam logic [31:0] EB = 32'hE0E00000;

  ctrl_model m (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
    .addr(addr), .dqm(dqm), .dq_wr(dq_in), .auto_grade(auto_grade));
  sdr_sdram_core DUT (.clk(clk), .rst(rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .auto_grade(auto_grade), .bank_open(bank_open), .burst_active(burst_active),
    .pwr_state(pwr_state), .mode_reg(mode_reg));
  //////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic check_pwr(input pwr_state_t got, input pwr_state_t exp);
    check({27'h0, got}, {27'h0, exp}, "power state");
  endtask : check_pwr
  task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a);
    m.issue(1'b0, c, b, a, 4'h0, 32'h0);
  endtask : cmd
  task automatic wr4(input logic [1:0] b, input logic [11:0] a, input logic [31:0] d, input logic [3:0] m2);
    m.issue(1'b0, CMD_WR, b, a, 4'h0, d);
    m.beat(d + 32'h1, 4'h0);
    m.beat(d + 32'h2, m2);
    m.beat(d + 32'h3, 4'h0);
  endtask : wr4
  // word j shows after edge j+lat-1; mask taken one edge after the read hides lane 0 after edge 2
  task automatic rd4(input int lat, input logic [1:0] b, input logic [11:0] a, input logic [31:0] e [4]);
    logic [31:0] lanes;
    cmd(CMD_RD, b, a);
    for (int p = 0; p < lat + 3; p++) begin
      lanes = (p == 2) ? 32'hFFFFFF00 : 32'hFFFFFFFF;
      if (p >= lat - 1) check(dq_out & lanes, e[p-lat+1] & lanes, "read word");
      if (p >= lat - 1) check({28'h0, dq_oe}, (p == 2) ? 32'hE : 32'hF, "lane enable");
      if (p < lat + 2) m.beat(32'h0, (p == 0) ? 4'h1 : 4'h0);
    end
    check({31'h0, burst_active}, 32'h0, "burst end");
  endtask : rd4
  //////////////////////////////////////////////////////////////
  task automatic t_basic();
    check({20'h0, mode_reg}, 32'h020, "reset mode");
    check({27'h0, burst_active, bank_open}, 32'h0, "reset state");
    check({28'h0, dq_oe}, 32'h0, "reset drive");
    check_pwr(pwr_state, PWR_RUN);
    cmd(CMD_LMR, 2'h0, 12'h022);
    check({20'h0, mode_reg}, 32'h022, "load mode");
    cmd(CMD_ACT, 2'h1, 12'h005);
    check({28'h0, bank_open}, 32'h2, "activate");
    m.issue(1'b1, CMD_ACT, 2'h2, 12'h005, 4'h0, 32'h0);
    check({28'h0, bank_open}, 32'h2, "deselected");
    wr4(2'h1, 12'h006, DB, 4'h0);
    rd4(2, 2'h1, 12'h004, '{DB + 2, DB + 3, DB, DB + 1});
    wr4(2'h1, 12'h004, EB, 4'h8);
    rd4(2, 2'h1, 12'h004, '{EB, EB + 1, 32'hD0E00002, EB + 3});
  endtask : t_basic
  task automatic t_order();
    cmd(CMD_PRE, 2'h0, 12'h400);
    cmd(CMD_LMR, 2'h0, 12'h03A);
    cmd(CMD_ACT, 2'h1, 12'h005);
    rd4(3, 2'h1, 12'h005, '{EB + 1, EB, EB + 3, 32'hD0E00002});
    cmd(CMD_PRE, 2'h0, 12'h400);
    cmd(CMD_LMR, 2'h0, 12'h012);
  endtask : t_order
  task automatic t_banks();
    for (int i = 0; i < 4; i++) cmd(CMD_ACT, 2'(i), 12'h000);
    check({28'h0, bank_open}, 32'hF, "all open");
    m.issue(1'b0, CMD_WR, 2'h0, 12'h008, 4'h0, DB);
    m.issue(1'b0, CMD_PRE, 2'h3, 12'h000, 4'h0, DB + 1);
    m.beat(DB + 2, 4'h0);
    m.beat(DB + 3, 4'h0);
    check({27'h0, burst_active, bank_open}, 32'h7, "one bank shut");
    rd4(1, 2'h0, 12'h008, '{DB, DB + 1, DB + 2, DB + 3});
    wr4(2'h1, 12'h404, EB, 4'h0);
    check({28'h0, bank_open}, 32'h5, "auto precharge");
    cmd(CMD_PRE, 2'h1, 12'h400);
    check({28'h0, bank_open}, 32'h0, "all shut");
  endtask : t_banks
  task automatic t_lengths();
    logic [2:0] code [5];
    int         n;
    code = '{BL_1, BL_2, BL_4, BL_8, BL_FULL};
    for (int i = 0; i < 5; i++) begin
      cmd(CMD_LMR, 2'h0, {9'h004, code[i]});
      cmd(CMD_ACT, 2'h0, 12'h000);
      cmd(CMD_WR, 2'h0, 12'h000);
      n = 0;
      while (burst_active === 1'b1 && n < 9) begin
        m.idle(1);
        n++;
      end
      check(32'(n), (i == 4) ? 32'd9 : (32'd1 << i) - 32'd1, "burst beats");
      cmd(CMD_BST, 2'h0, 12'h000);
      check({31'h0, burst_active}, 32'h0, "terminate");
      cmd(CMD_PRE, 2'h0, 12'h400);
    end
  endtask : t_lengths
  task automatic t_power();
    for (int i = 0; i < 3; i++) begin
      m.set_gate(1'b0, i == 2);
      m.issue(i == 0, CMD_REF, 2'h0, 12'h000, 4'h0, 32'h0);
      check_pwr(pwr_state, (i == 1) ? PWR_SELF : PWR_PD_PRE);
      m.set_gate(1'b1, 1'b0);
      cmd(CMD_ACT, 2'h0, 12'h000);
      check_pwr(pwr_state, PWR_RUN);
      check({28'h0, bank_open}, 32'h0, "exit command");
    end
    cmd(CMD_ACT, 2'h0, 12'h000);
    m.set_gate(1'b0, 1'b0);
    cmd(CMD_PRE, 2'h0, 12'h400);
    check_pwr(pwr_state, PWR_PD_ACT);
    m.set_gate(1'b1, 1'b0);
    cmd(CMD_PRE, 2'h0, 12'h400);
    check({28'h0, bank_open}, 32'h1, "gated command");
    cmd(CMD_WR, 2'h0, 12'h000);
    m.set_gate(1'b0, 1'b0);
    m.idle(1);
    check_pwr(pwr_state, PWR_SUSPEND);
    m.set_gate(1'b1, 1'b0);
    m.idle(1);
    cmd(CMD_BST, 2'h0, 12'h000);
  endtask : t_power
  //////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ceiling well above the hundred or so cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    m.idle(1);
    t_basic();
    t_order();
    t_banks();
    t_lengths();
    t_power();
    end_of_test();
  end
endmodule : test_sdr_sdram_core
